// *** prd_node.sv ***
// network node end: restart procedure, header decode, apb registers
// assumes the terminal end on prd_link_if and an apb master on pclk
`timescale 1ns/100ps
`default_nettype none
`include "prd_regs.svh"
module prd_node
  import prd_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // link
  prd_link_if.node link
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic m128_q;
  logic [`PRD_IRQ_W-1:0] irq_st_q;
  logic [`PRD_IRQ_W-1:0] mask_q;
  logic [23:0] hdr_q;
  prd_rst_t st_q;
  logic ind_cmd;
  logic req_cmd;
  logic wr_acc;
  logic rd_acc;
  // receive side
  logic [23:0] rx_sh_q;
  logic [4:0] rx_cnt_q;
  logic rx_done;
  logic [23:0] rx_hdr;
  prd_kind_t rx_kind;
  // transmit side
  logic [7:0] tx_oct_q;
  logic [2:0] tx_bit_q;
  logic [1:0] tx_octn_q;
  logic tx_busy_q;
  logic tx_start;
  logic [7:0] tx_code;
  logic [7:0] tx_o1;
  logic n2t_bit_q;
  logic n2t_valid_q;
  logic n2t_end_q;
  logic [`PRD_IRQ_W-1:0] ev;

  assign wr_acc = psel && penable && pwrite && pready_q;
  assign rd_acc = psel && penable && !pwrite && pready_q;
  assign ind_cmd = wr_acc && (paddr == `PRD_CTRL_OFS) && pwdata[`PRD_CTRL_IND_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // apb access: one wait state, answer on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      if (psel && penable && !pready_q) begin
        if (paddr == `PRD_CTRL_OFS) begin
          prdata_q <= {29'h0, m128_q, 2'h0};
        end else if (paddr == `PRD_STAT_OFS) begin
          prdata_q <= {30'h0, st_q};
        end else if (paddr == `PRD_IRQ_OFS) begin
          prdata_q <= {28'h0, irq_st_q};
        end else if (paddr == `PRD_MASK_OFS) begin
          prdata_q <= {28'h0, mask_q};
        end else if (paddr == `PRD_HDR_OFS) begin
          prdata_q <= {8'h0, hdr_q};
        end else begin
          prdata_q <= 32'h0;
          pslverr_q <= 1'b1;
        end
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m128_q <= 1'b0;
      mask_q <= '0;
    end else if (wr_acc && paddr == `PRD_CTRL_OFS) begin
      m128_q <= pwdata[`PRD_CTRL_M128_BIT];
    end else if (wr_acc && paddr == `PRD_MASK_OFS) begin
      mask_q <= pwdata[`PRD_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // deserialise the three header octets, bit 1 first, octet 1 first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_q <= '0;
      rx_cnt_q <= '0;
    end else if (link.t2n_valid && !link.t2n_end) begin
      if (rx_cnt_q < 5'd24) begin
        rx_sh_q[rx_cnt_q] <= link.t2n_bit;
        rx_cnt_q <= rx_cnt_q + 5'd1;
      end
    end else if (link.t2n_end) begin
      rx_cnt_q <= '0;
    end
  end
  assign rx_done = link.t2n_end && (rx_cnt_q >= 5'd24);
  assign rx_hdr = rx_sh_q;
  assign rx_kind = prd_classify(rx_hdr[7:0], rx_hdr[23:16]);

  // latch last header taken outside node indication: octet1 gfi/group, octet2 channel, octet3 type
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_q <= '0;
    end else if (rx_done && st_q != PRD_ST_NODE_IND) begin
      hdr_q <= rx_hdr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // restart state machine
  assign req_cmd = rx_done && rx_kind == PRD_PK_RESTART;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= PRD_ST_READY;
    end else begin
      case (st_q)
        PRD_ST_READY: begin
          if (req_cmd) begin
            st_q <= PRD_ST_TERM_REQ;
          end else if (ind_cmd && !tx_busy_q) begin
            st_q <= PRD_ST_NODE_IND;
          end
        end
        PRD_ST_TERM_REQ: begin
          if (tx_start) begin
            st_q <= PRD_ST_READY;
          end
        end
        PRD_ST_NODE_IND: begin
          if (rx_done && (rx_kind == PRD_PK_RESTART_CONF || rx_kind == PRD_PK_RESTART)) begin
            st_q <= PRD_ST_READY;
          end
        end
        default: st_q <= PRD_ST_READY;
      endcase
    end
  end

  // confirmation sent for a terminal request; none after a collision
  assign tx_start = (st_q == PRD_ST_TERM_REQ && !tx_busy_q) ||
                    (st_q == PRD_ST_READY && ind_cmd && !req_cmd && !tx_busy_q);
  assign tx_code = (st_q == PRD_ST_TERM_REQ) ? `PRD_PT_RSTRTC : `PRD_PT_RSTRT;
  assign tx_o1 = {1'b0, (m128_q ? `PRD_GFI_M128 : `PRD_GFI_M8), 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: octet1 = gfi with zero group, octet2 zero, octet3 code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_q <= 1'b0;
      tx_oct_q <= '0;
      tx_bit_q <= '0;
      tx_octn_q <= '0;
      n2t_bit_q <= 1'b0;
      n2t_valid_q <= 1'b0;
      n2t_end_q <= 1'b0;
    end else begin
      n2t_end_q <= 1'b0;
      if (tx_start) begin
        tx_busy_q <= 1'b1;
        tx_oct_q <= tx_code;
        tx_bit_q <= '0;
        tx_octn_q <= '0;
        n2t_valid_q <= 1'b1;
        n2t_bit_q <= 1'b0; // octet 1 bit 1: group lsb, zero in restart packets
      end else if (tx_busy_q) begin
        if (tx_bit_q == 3'd7 && tx_octn_q == 2'd2) begin
          tx_busy_q <= 1'b0;
          n2t_valid_q <= 1'b0;
          n2t_end_q <= 1'b1;
        end else begin
          tx_bit_q <= tx_bit_q + 3'd1;
          if (tx_bit_q == 3'd7) begin
            tx_octn_q <= tx_octn_q + 2'd1;
          end
          case (tx_bit_q == 3'd7 ? tx_octn_q + 2'd1 : tx_octn_q)
            2'd0: n2t_bit_q <= tx_o1[tx_bit_q + 3'd1];
            2'd1: n2t_bit_q <= 1'b0;
            default: n2t_bit_q <= tx_oct_q[tx_bit_q + 3'd1];
          endcase
        end
      end
    end
  end
  assign link.n2t_bit = n2t_bit_q;
  assign link.n2t_valid = n2t_valid_q;
  assign link.n2t_end = n2t_end_q;

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear, set wins
  assign ev[`PRD_IRQ_DONE_BIT] = (st_q != PRD_ST_READY) && (tx_start || (st_q ==
                                 PRD_ST_NODE_IND && rx_done &&
                                 (rx_kind == PRD_PK_RESTART_CONF || rx_kind == PRD_PK_RESTART)));
  assign ev[`PRD_IRQ_FERR_BIT] = rx_done && rx_kind == PRD_PK_BAD;
  assign ev[`PRD_IRQ_DISC_BIT] = rx_done && st_q == PRD_ST_NODE_IND &&
                                 (rx_kind == PRD_PK_DATA || rx_kind == PRD_PK_CHAN);
  assign ev[`PRD_IRQ_RX_BIT] = rx_done && st_q != PRD_ST_NODE_IND &&
                               (rx_kind == PRD_PK_DATA || rx_kind == PRD_PK_CHAN);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_st_q <= ev | (irq_st_q & ~((wr_acc && paddr == `PRD_IRQ_OFS) ?
                  pwdata[`PRD_IRQ_W-1:0] : {`PRD_IRQ_W{1'b0}}));
      irq_q <= |(irq_st_q & mask_q);
    end
  end
  assign irq = irq_q;
endmodule : prd_node
`default_nettype wire

// *** prd_regs.svh ***
// constants of the packet restart and header decoder: offsets, fields, codes
// assumes a single pclk domain and an apb slave on the node end
// Operation
// - terminal may request restart at any time
// - node answers request with restart confirmation
// - node may start restart with indication
// - node discards channel packets while indicating
// - terminal confirms a node restart indication
// - crossing request and indication completes restart
// - bit 1 first, octets ascending order
// - format identifier in octet 1 bits 8..5
// - identifier 001 mod 8, 010 mod 128
// - group number in octet 1 bits 4..1
// - channel number fills octet 2
// - call packet type codes in octet 3
// - data has bit1 zero; interrupt codes
// - flow control and reset type codes
// - restart codes 11111011 and 11111111
// - completed restart clears calls, resets circuits; no call or circuit state is kept here
// - modulo 8 data sequence field layout
`ifndef PRD_REGS_SVH
`define PRD_REGS_SVH
// apb register offsets
`define PRD_CTRL_OFS 12'h000
`define PRD_STAT_OFS 12'h004
`define PRD_IRQ_OFS 12'h008
`define PRD_MASK_OFS 12'h00c
`define PRD_HDR_OFS 12'h010
// control bits
`define PRD_CTRL_IND_BIT 0
`define PRD_CTRL_REQ_BIT 1
`define PRD_CTRL_M128_BIT 2
// irq bits
`define PRD_IRQ_DONE_BIT 0
`define PRD_IRQ_FERR_BIT 1
`define PRD_IRQ_DISC_BIT 2
`define PRD_IRQ_RX_BIT 3
`define PRD_IRQ_W 4
// header fields
`define PRD_GFI_MSB 7
`define PRD_GFI_LSB 4
`define PRD_LCG_MSB 3
`define PRD_LCG_LSB 0
`define PRD_GFI_M8 3'h1
`define PRD_GFI_M128 3'h2
// packet type codes
`define PRD_PT_CALL 8'h0b
`define PRD_PT_CONN 8'h0f
`define PRD_PT_CLR 8'h13
`define PRD_PT_CLRC 8'h17
`define PRD_PT_INT 8'h23
`define PRD_PT_INTC 8'h27
`define PRD_PT_RR 5'h01
`define PRD_PT_RNR 5'h05
`define PRD_PT_REJ 5'h09
`define PRD_PT_RST 8'h1b
`define PRD_PT_RSTC 8'h1f
`define PRD_PT_RSTRT 8'hfb
`define PRD_PT_RSTRTC 8'hff
// mod 8 data fields
`define PRD_PR_MSB 7
`define PRD_PR_LSB 5
`define PRD_MORE_BIT 4
`define PRD_PS_MSB 3
`define PRD_PS_LSB 1
`define PRD_HDR_OCTETS 3
`endif

// *** prd_pkg.sv ***
// types shared by both ends of the packet link
// assumes prd_regs.svh constants
`include "prd_regs.svh"
package prd_pkg;
  typedef enum logic [2:0] {
    PRD_PK_DATA = 3'h0,
    PRD_PK_RESTART = 3'h1,
    PRD_PK_RESTART_CONF = 3'h2,
    PRD_PK_CHAN = 3'h3,
    PRD_PK_BAD = 3'h4
  } prd_kind_t;
  typedef enum logic [1:0] {
    PRD_ST_READY = 2'h0,
    PRD_ST_TERM_REQ = 2'h1,
    PRD_ST_NODE_IND = 2'h2
  } prd_rst_t;
  // classify octet 3 and octet 1
  function automatic prd_kind_t prd_classify(input logic [7:0] o1, input logic [7:0] o3);
    logic [2:0] g;
    logic ok;
    g = o1[`PRD_GFI_MSB-1:`PRD_GFI_LSB];
    ok = (g == `PRD_GFI_M8) || (g == `PRD_GFI_M128);
    if (!ok) begin
      prd_classify = PRD_PK_BAD;
    end else if (o3[0] == 1'b0) begin
      prd_classify = PRD_PK_DATA;
    end else if (o1[`PRD_GFI_MSB]) begin
      prd_classify = PRD_PK_BAD;
    end else if (o3 == `PRD_PT_RSTRT) begin
      prd_classify = PRD_PK_RESTART;
    end else if (o3 == `PRD_PT_RSTRTC) begin
      prd_classify = PRD_PK_RESTART_CONF;
    end else if (o3 == `PRD_PT_CALL || o3 == `PRD_PT_CONN || o3 == `PRD_PT_CLR ||
                 o3 == `PRD_PT_CLRC || o3 == `PRD_PT_INT || o3 == `PRD_PT_INTC ||
                 o3 == `PRD_PT_RST || o3 == `PRD_PT_RSTC || o3[4:0] == `PRD_PT_RR ||
                 o3[4:0] == `PRD_PT_RNR || o3[4:0] == `PRD_PT_REJ) begin
      prd_classify = PRD_PK_CHAN;
    end else begin
      prd_classify = PRD_PK_BAD;
    end
  endfunction : prd_classify
endpackage : prd_pkg

// *** prd_link_if.sv ***
// serial packet link between node and terminal, bit 1 of each octet first
// assumes both ends share pclk
`timescale 1ns/100ps
`default_nettype none
interface prd_link_if (input wire logic pclk);
  logic n2t_bit;
  logic n2t_valid;
  logic n2t_end;
  logic t2n_bit;
  logic t2n_valid;
  logic t2n_end;
  modport node (input pclk, output n2t_bit, output n2t_valid, output n2t_end,
                input t2n_bit, input t2n_valid, input t2n_end);
  modport term (input pclk, input n2t_bit, input n2t_valid, input n2t_end,
                output t2n_bit, output t2n_valid, output t2n_end);
endinterface : prd_link_if
`default_nettype wire

// *** prd_term.sv ***
// terminal end: sends restart requests, confirms node indications
// assumes the node end on prd_link_if; plain user port for the request
`timescale 1ns/100ps
`default_nettype none
`include "prd_regs.svh"
module prd_term
  import prd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // user side
  input wire logic restart_req,
  input wire logic m128,
  output logic busy,
  output logic restart_done,
  // link
  prd_link_if.term link
);
  ////////////////////////////////////////////////////////////////////////////
  logic [23:0] sh_q;
  logic [4:0] rcnt_q;
  logic [23:0] tx_q;
  logic [4:0] tcnt_q;
  logic busy_q;
  logic done_q;
  logic bit_q;
  logic valid_q;
  logic end_q;
  logic rx_done;
  prd_kind_t kind;
  logic send;
  logic [7:0] code;

  // receive header bits, bit 1 first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= '0;
      rcnt_q <= '0;
    end else if (link.n2t_valid) begin
      if (rcnt_q < 5'd24) begin
        sh_q[rcnt_q] <= link.n2t_bit;
        rcnt_q <= rcnt_q + 5'd1;
      end
    end else if (link.n2t_end) begin
      rcnt_q <= '0;
    end
  end
  assign rx_done = link.n2t_end && rcnt_q >= 5'd24;
  assign kind = prd_classify(sh_q[7:0], sh_q[23:16]);

  // confirm an indication, or send a user request
  assign send = !busy_q && ((rx_done && kind == PRD_PK_RESTART) || restart_req);
  assign code = (rx_done && kind == PRD_PK_RESTART) ? `PRD_PT_RSTRTC : `PRD_PT_RSTRT;

  ////////////////////////////////////////////////////////////////////////////
  // serial transmitter of a three octet restart header
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= '0;
      tcnt_q <= '0;
      busy_q <= 1'b0;
      bit_q <= 1'b0;
      valid_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      end_q <= 1'b0;
      if (send) begin
        tx_q <= {code, 8'h00, 2'h0, m128, !m128, 4'h0};
        tcnt_q <= '0;
        busy_q <= 1'b1;
        valid_q <= 1'b1;
        bit_q <= 1'b0;
      end else if (busy_q) begin
        if (tcnt_q == 5'd23) begin
          busy_q <= 1'b0;
          valid_q <= 1'b0;
          end_q <= 1'b1;
        end else begin
          tcnt_q <= tcnt_q + 5'd1;
          bit_q <= tx_q[tcnt_q + 5'd1];
        end
      end
    end
  end
  assign link.t2n_bit = bit_q;
  assign link.t2n_valid = valid_q;
  assign link.t2n_end = end_q;

  // completion pulse on a node confirmation or on any node indication
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= rx_done && (kind == PRD_PK_RESTART_CONF || kind == PRD_PK_RESTART);
    end
  end
  assign busy = busy_q;
  assign restart_done = done_q;
endmodule : prd_term
`default_nettype wire

// *** prd_link_props.sv ***
// wire checks on the node and terminal link of the packet restart decoder
// assumes both ends on one prd_link_if, frames of 24 bits, bit 1 of octet 1 first
`timescale 1ns/100ps
`default_nettype none
module prd_link_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // node to terminal
  input wire logic n2t_bit,
  input wire logic n2t_valid,
  input wire logic n2t_end,
  // terminal to node
  input wire logic t2n_bit,
  input wire logic t2n_valid,
  input wire logic t2n_end
);
  logic [4:0] nc_q;
  logic [4:0] tc_q;
  logic n_ind_q;
  logic t_req_q;
  logic open_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  // bit index within each frame, kind of restart packet, indication awaiting reply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nc_q <= 5'h00;
      tc_q <= 5'h00;
      n_ind_q <= 1'b0;
      t_req_q <= 1'b0;
      open_q <= 1'b0;
    end else begin
      nc_q <= n2t_valid ? nc_q + 5'h01 : 5'h00;
      tc_q <= t2n_valid ? tc_q + 5'h01 : 5'h00;
      if (n2t_valid && nc_q == 5'h12) n_ind_q <= !n2t_bit;
      if (t2n_valid && tc_q == 5'h12) t_req_q <= !t2n_bit;
      if (n2t_end && n_ind_q) open_q <= 1'b1;
      else if (t2n_end) open_q <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // framing, header codes and answers
  n_len_a: assert property (n2t_end |-> nc_q == 5'h18) else $error("node frame length");
  t_len_a: assert property (t2n_end |-> tc_q == 5'h18) else $error("term frame length");
  n_end_a: assert property ($fell(n2t_valid) |-> n2t_end ##1 !n2t_end)
    else $error("node end pulse");
  n_code_a: assert property (n2t_valid && nc_q[4] && nc_q != 5'h12 |-> n2t_bit)
    else $error("node restart code");
  t_code_a: assert property (t2n_valid && tc_q[4] && tc_q != 5'h12 |-> t2n_bit)
    else $error("term restart code");
  n_gfi_a: assert property (n2t_valid && nc_q inside {5'h06, 5'h07} |-> !n2t_bit)
    else $error("node format id");
  t_gfi_a: assert property (t2n_valid && tc_q inside {5'h06, 5'h07} |-> !t2n_bit)
    else $error("term format id");
  node_conf_a: assert property (t2n_end && t_req_q && !open_q |-> ##[1:4] n2t_valid)
    else $error("node did not confirm");
  term_conf_a: assert property (n2t_end && n_ind_q |-> ##[1:4] t2n_valid)
    else $error("terminal did not confirm");
  cover property (t2n_end && t_req_q);
  cover property (n2t_end && n_ind_q);
  cover property (t2n_end && !t_req_q);
endmodule : prd_link_props
`default_nettype wire

// *** tb.sv ***
// self-checking bench: node and terminal joined, plus a node driven by the bench
// assumes prd_regs.svh offsets and a 25 MHz pclk
`timescale 1ns/100ps
`default_nettype none
`include "prd_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic pclk, presetn, pwrite, penable, restart_req, m128, busy, restart_done, err;
  logic [1:0] psel, rdy, serr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [31:0] prd [2];
  int fails, n_tests;
  logic [23:0] pk_tab [14] = '{24'h0b0035, 24'h030010, 24'h0b0090, 24'h0b3c15, 24'h0f3c15,
    24'h133c15, 24'h173c15, 24'h233c15, 24'h273c15, 24'h1b3c15, 24'h1f3c15, 24'he13c15,
    24'ha53c15, 24'h493c15};
  prd_link_if lk (.pclk(pclk));
  prd_link_if lk2 (.pclk(pclk));
  //////////////////////////////////////////////////////////////////////////////
  // design ends and wire checker
  prd_node prd_node_i (.pclk(pclk), .presetn(presetn), .psel(psel[0]), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd[0]), .pready(rdy[0]),
    .pslverr(serr[0]), .irq(irq[0]), .link(lk.node));
  prd_node prd_node_i2 (.pclk(pclk), .presetn(presetn), .psel(psel[1]), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd[1]), .pready(rdy[1]),
    .pslverr(serr[1]), .irq(irq[1]), .link(lk2.node));
  prd_term prd_term_i (.pclk(pclk), .presetn(presetn), .restart_req(restart_req), .m128(m128),
    .busy(busy), .restart_done(restart_done), .link(lk.term));
  prd_link_props prd_link_props_i (.pclk(pclk), .presetn(presetn), .n2t_bit(lk.n2t_bit),
    .n2t_valid(lk.n2t_valid), .n2t_end(lk.n2t_end), .t2n_bit(lk.t2n_bit),
    .t2n_valid(lk.t2n_valid), .t2n_end(lk.t2n_end));
  //////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
  //////////////////////////////////////////////////////////////////////////////
  // apb transfer on node s, held until pready is seen high
  task automatic apb(input int s, input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel[s] <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (rdy[s] !== 1'b1);
    rd = prd[s];
    err = serr[s];
    psel <= 2'b00;
    penable <= 1'b0;
  endtask : apb
  // one 24-bit header to the second node, bit 1 of octet 1 first
  task automatic send(input logic [23:0] pk);
    for (int i = 0; i < 24; i++) begin
      @(posedge pclk);
      lk2.t2n_valid <= 1'b1;
      lk2.t2n_bit <= pk[i];
    end
    @(posedge pclk);
    lk2.t2n_valid <= 1'b0;
    lk2.t2n_end <= 1'b1;
    lk2.t2n_bit <= ~pk[23];
    @(posedge pclk);
    lk2.t2n_end <= 1'b0;
  endtask : send
  // read the event register until bit b is set, bounded
  task automatic poll(input int s, input int b);
    rd = 32'h0;
    for (int k = 0; k < 60 && rd[b] !== 1'b1; k++) apb(s, 1'b0, `PRD_IRQ_OFS, 32'h0);
  endtask : poll
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    fails = 0; n_tests = 0; presetn = 1'b0; psel = 2'b00; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; restart_req = 1'b0; m128 = 1'b0; rd = 32'h0; err = 1'b0;
    lk2.t2n_bit = 1'b0; lk2.t2n_valid = 1'b0; lk2.t2n_end = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 1'b0, `PRD_STAT_OFS, 32'h0); `CHK(rd[1:0], 2'h0)
    apb(0, 1'b0, 12'h020, 32'h0); `CHK(err, 1'b1)
    $display("test reset done");
    // terminal restart answered by the node
    apb(0, 1'b1, `PRD_MASK_OFS, 32'h1);
    restart_req <= 1'b1;
    @(posedge pclk);
    restart_req <= 1'b0;
    @(posedge pclk);
    `CHK(busy, 1'b1)
    for (int k = 0; k < 60 && lk.t2n_end !== 1'b1; k++) @(posedge pclk);
    // the request state lasts one cycle, so the answer on the wire is watched
    repeat (2) @(posedge pclk);
    `CHK(lk.n2t_valid, 1'b1)
    for (int k = 0; k < 80 && restart_done !== 1'b1; k++) @(posedge pclk);
    `CHK(restart_done, 1'b1)
    apb(0, 1'b0, `PRD_IRQ_OFS, 32'h0); `CHK(rd[3:0], 4'h1)
    `CHK(irq[0], 1'b1)
    apb(0, 1'b0, `PRD_STAT_OFS, 32'h0); `CHK(rd[1:0], 2'h0)
    apb(0, 1'b0, `PRD_HDR_OFS, 32'h0); `CHK(rd[23:0], 24'hfb0010)
    apb(0, 1'b1, `PRD_IRQ_OFS, 32'hf);
    repeat (2) @(posedge pclk);
    `CHK(irq[0], 1'b0)
    $display("test terminal restart done");
    // node indication, masked, modulo 128
    m128 <= 1'b1;
    apb(0, 1'b1, `PRD_MASK_OFS, 32'h0);
    apb(0, 1'b1, `PRD_CTRL_OFS, 32'h5);
    apb(0, 1'b0, `PRD_STAT_OFS, 32'h0); `CHK(rd[1:0], 2'h2)
    poll(0, 0); `CHK(rd[0], 1'b1)
    `CHK(irq[0], 1'b0)
    apb(0, 1'b0, `PRD_STAT_OFS, 32'h0); `CHK(rd[1:0], 2'h0)
    // headers taken while indicating are not latched
    apb(0, 1'b0, `PRD_HDR_OFS, 32'h0); `CHK(rd[23:0], 24'hfb0010)
    $display("test node restart done");
    // bad headers and every channel packet code on the second node
    for (int i = 0; i < 14; i++) begin
      send(pk_tab[i]);
      poll(1, i < 3 ? 1 : 3); `CHK(rd[i < 3 ? 1 : 3], 1'b1)
      apb(1, 1'b0, `PRD_HDR_OFS, 32'h0);
      if (i > 2) `CHK(rd[23:0], pk_tab[i])
      apb(1, 1'b1, `PRD_IRQ_OFS, 32'hf);
    end
    send(24'hb63c95);
    apb(1, 1'b0, `PRD_HDR_OFS, 32'h0); `CHK(rd[23:0], 24'hb63c95)
    apb(1, 1'b0, `PRD_IRQ_OFS, 32'h0); `CHK(rd[1], 1'b0)
    $display("test header decode done");
    // discard while indicating, then a crossing request
    apb(1, 1'b1, `PRD_CTRL_OFS, 32'h1);
    apb(1, 1'b1, `PRD_IRQ_OFS, 32'hf);
    apb(1, 1'b0, `PRD_STAT_OFS, 32'h0); `CHK(rd[1:0], 2'h2)
    send(24'hb63c15);
    poll(1, 2); `CHK(rd[3:0], 4'h4)
    send(24'hfb0010);
    repeat (4) begin
      @(posedge pclk);
      `CHK(lk2.n2t_valid, 1'b0)
    end
    apb(1, 1'b0, `PRD_STAT_OFS, 32'h0); `CHK(rd[1:0], 2'h0)
    apb(1, 1'b0, `PRD_IRQ_OFS, 32'h0); `CHK(rd[0], 1'b1)
    $display("test collision done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
